// ---- verilog/sar_ctrl_pkg.sv ----
// Constants, field layouts and state types for the converter control sequencer.
// Assumes a single 125 MHz core clock with all host pins already synchronous to it.
//
// Summary of operation
// [RULE1] Write with acquisition select zero starts timed acquisition.
// [RULE2] Timed acquisition: three clocks, or 1 us internal.
// [RULE3] Write with acquisition select one acquires indefinitely.
// [RULE4] Second write, select zero, launches conversion on strobe.
// [RULE5] Host repeats channel select on both writes.
// [RULE6] Power bits may change on second write safely.
// [RULE7] Host keeps other fields unchanged between writes.
// [RULE8] Done output falls when result is ready.
// [RULE9] Done output rises on read or new write.
// [RULE10] Power-down modes keep the last clock source.
// [RULE11] Top two bits decode power and clock modes.
// [RULE12] Bit five selects timed or host acquisition.
// [RULE13] Bit four selects differential or single-ended inputs.
// [RULE14] Bit three selects bipolar or unipolar conversion.
// [RULE15] Low three bits select the input channel.
// [RULE16] External conversion clock is used after power-up.
// [RULE17] Internal clock converts in about 3.6 us.
// [RULE18] Both acquisition methods work with both clocks.
// [RULE19] Internal clock users prefer host-timed acquisition.
// [RULE20] Each conversion takes thirteen conversion clock cycles.
// [RULE21] Write during conversion aborts and restarts acquisition.
// [RULE22] Track on write rise; hold on fourth falling edge.
// [RULE23] Chip select high ignores clock, write, read; bus off.
// [RULE24] Internal clock mode ignores the external clock input.

package sar_ctrl_pkg;

    // ************************************************************
    // Timing figures and derived cycle counts
    // ************************************************************

    // Core clock period in nanoseconds.
    localparam int CORE_PERIOD_NS = 8;
    // Internally timed acquisition length on the internal clock, in nanoseconds.
    localparam int ACQ_INT_TIME_NS = 1000;
    // Longest time, so the cycle count rounds down.
    localparam int ACQ_INT_CYCLES = ACQ_INT_TIME_NS / CORE_PERIOD_NS;
    // Conversion time on the internal oscillator, in nanoseconds.
    localparam int CONV_INT_TIME_NS = 3600;
    // Number of conversion clock cycles in one conversion.
    localparam int CONV_STEPS = 13;
    // Core cycles per internal conversion clock step, rounded down.
    localparam int INT_STEP_CYCLES = CONV_INT_TIME_NS / (CONV_STEPS * CORE_PERIOD_NS);
    // Hold begins on this falling external clock edge after the write.
    localparam int ACQ_EXT_FALL_EDGES = 4;
    // Index of the last conversion step.
    localparam logic [3:0] CONV_LAST_STEP = 4'(CONV_STEPS - 1);
    // Width of the acquisition and oscillator counters.
    localparam int CNT_W = 8;

    // ************************************************************
    // Control byte layout and codes
    // ************************************************************

    // Control byte fields, most significant bit first.
    typedef struct packed {
        logic       power_clock_select_hi; // High bit of the power/clock field.
        logic       power_clock_select_lo; // Low bit of the power/clock field.
        logic       acquisition_select;    // One selects host-timed acquisition.
        logic       input_config_select;   // One selects single-ended inputs.
        logic       polarity_select;       // One selects unipolar conversion.
        logic [2:0] channel_select;        // Input channel code.
    } cfg_s;

    // Power/clock field codes.
    localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
    localparam logic [1:0] PWR_STANDBY   = 2'h1;
    localparam logic [1:0] PWR_INT_CLK   = 2'h2;
    localparam logic [1:0] PWR_EXT_CLK   = 2'h3;
    // Power-up control value: normal operation on the external clock.
    localparam logic [7:0] CTRL_RESET = 8'hc0;
    // First trial code of a successive approximation.
    localparam logic [11:0] SAR_FIRST = 12'h800;

    // ************************************************************
    // State types
    // ************************************************************

    // Sequencer states.
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_ACQ_TIMED,
        SEQ_ACQ_HOST,
        SEQ_CONVERT
    } seq_e;

    // Whole state of the sequencer.
    typedef struct packed {
        seq_e             state;        // Sequencer state.
        cfg_s             cfg;          // Last control byte taken.
        logic             clk_internal; // One while the internal oscillator is used.
        logic             wr_n_prev;    // Write strobe one cycle ago.
        logic             rd_n_prev;    // Read strobe one cycle ago.
        logic             ext_prev;     // External clock one cycle ago.
        logic [CNT_W-1:0] acq_cnt;      // Acquisition length counter.
        logic [3:0]       step;         // Conversion step index.
        logic [11:0]      trial;        // Trial code for the capacitive DAC.
        logic [11:0]      result;       // Last finished result.
        logic             done_n;       // Completion output, active low.
        logic             data_oe;      // Data bus drive enable.
        logic [7:0]       data_out;     // Data bus output byte.
        logic             track;        // One while the track/hold tracks.
        logic             converting;   // One during conversion.
        logic             power_down;   // Full power-down selected.
        logic             standby;      // Standby selected.
    } seq_s;

    // Sequencer reset value.
    localparam seq_s SEQ_RESET = '{
        state: SEQ_IDLE, cfg: cfg_s'(CTRL_RESET), clk_internal: 1'b0,
        wr_n_prev: 1'b1, rd_n_prev: 1'b1, ext_prev: 1'b0,
        acq_cnt: '0, step: 4'h0, trial: 12'h000, result: 12'h000,
        done_n: 1'b1, data_oe: 1'b0, data_out: 8'h00, track: 1'b0,
        converting: 1'b0, power_down: 1'b0, standby: 1'b0
    };

    // Whole state of the internal oscillator divider.
    typedef struct packed {
        logic [CNT_W-1:0] cnt;  // Core cycles within the current step.
        logic             tick; // One-cycle step pulse.
    } osc_s;

    // Oscillator reset value.
    localparam osc_s OSC_RESET = '{cnt: '0, tick: 1'b0};

endpackage

// ---- verilog/int_conv_clock.sv ----
// Internal conversion oscillator, built as a divider of the core clock.
// Assumes run is a level from the sequencer; the count restarts whenever run is low.

`timescale 1ns/1ps

module int_conv_clock #(
    parameter int STEP_CYCLES = sar_ctrl_pkg::INT_STEP_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      tick
);

    // ************************************************************
    // Divider state
    // ************************************************************

    // Last count of a step, sized to the counter.
    localparam logic [sar_ctrl_pkg::CNT_W-1:0] LAST = sar_ctrl_pkg::CNT_W'(STEP_CYCLES - 1);

    sar_ctrl_pkg::osc_s osc_reg;  // Registered divider state.
    sar_ctrl_pkg::osc_s osc_next; // Next divider state.

    // Count core cycles and pulse once per step; restarting on stop keeps
    // every conversion's first step a full step long.
    always_comb begin
        osc_next = osc_reg;
        osc_next.tick = 1'b0;
        if (!run) begin
            osc_next.cnt = '0;
        end else if (osc_reg.cnt == LAST) begin
            osc_next.cnt = '0;
            osc_next.tick = 1'b1;
        end else begin
            osc_next.cnt = osc_reg.cnt + 1'b1;
        end
    end

    // Register the divider state with a synchronous reset.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            osc_reg <= sar_ctrl_pkg::OSC_RESET;
        end else begin
            osc_reg <= osc_next;
        end
    end

    assign tick = osc_reg.tick;

endmodule

// ---- verilog/sar_adc_control_sequencer.sv ----
// Acquisition and conversion sequencer of a 12-bit successive-approximation converter.
// Assumes host strobes, the external clock and the comparator are synchronous to core_clk.

`timescale 1ns/1ps

module sar_adc_control_sequencer #(
    parameter int ACQ_CYCLES  = sar_ctrl_pkg::ACQ_INT_CYCLES,
    parameter int STEP_CYCLES = sar_ctrl_pkg::INT_STEP_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        cs_n,
    input  wire logic        wr_n,
    input  wire logic        rd_n,
    input  wire logic        ext_clk,
    input  wire logic        high_byte_select,
    input  wire logic [7:0]  data_in,
    input  wire logic        comparator_high,
    output logic             done_n,
    output logic [7:0]       data_out,
    output logic             data_oe,
    output logic             track,
    output logic             converting,
    output logic [11:0]      sar_trial,
    output logic [2:0]       channel_select,
    output logic             input_config_select,
    output logic             polarity_select,
    output logic             internal_clock,
    output logic             power_down,
    output logic             standby
);

    // ************************************************************
    // Local constants and helpers
    // ************************************************************

    // Last core cycle of internally timed acquisition.
    localparam logic [sar_ctrl_pkg::CNT_W-1:0] ACQ_INT_LAST =
        sar_ctrl_pkg::CNT_W'(ACQ_CYCLES - 1);
    // Last counted falling edge of externally clocked timed acquisition.
    localparam logic [sar_ctrl_pkg::CNT_W-1:0] ACQ_EXT_LAST =
        sar_ctrl_pkg::CNT_W'(sar_ctrl_pkg::ACQ_EXT_FALL_EDGES - 1);

    // One successive-approximation step: decide the bit under trial, then try the next.
    function automatic logic [11:0] sar_step(input logic [11:0] code,
                                             input logic [3:0]  idx,
                                             input logic        keep);
        logic [3:0]  bitpos;
        logic [11:0] r;
        bitpos = 4'hc - idx;
        r = code;
        if (idx == 4'h0) begin
            r = sar_ctrl_pkg::SAR_FIRST;
        end else begin
            r[bitpos] = keep;
            if (bitpos != 4'h0) begin
                r[bitpos - 4'h1] = 1'b1;
            end
        end
        return r;
    endfunction

    // Byte placed on the bus for a read; the high byte carries sign fill in bipolar mode.
    function automatic logic [7:0] read_byte(input logic [11:0] res,
                                             input logic        hi,
                                             input logic        unipolar);
        logic [3:0] fill;
        fill = unipolar ? 4'h0 : {4{res[11]}};
        return hi ? {fill, res[11:8]} : res[7:0];
    endfunction

    // ************************************************************
    // State and strobe decode
    // ************************************************************

    sar_ctrl_pkg::seq_s st_reg;  // Registered sequencer state.
    sar_ctrl_pkg::seq_s st_next; // Next sequencer state.
    sar_ctrl_pkg::cfg_s new_cfg; // Control byte on the data pins.
    logic               wr_rise; // Write strobe rising edge while selected.
    logic               rd_fall; // Read strobe falling edge while selected.
    logic               ext_rise;  // External clock rising edge while selected.
    logic               ext_fall;  // External clock falling edge while selected.
    logic               int_tick;  // Internal oscillator step pulse.
    logic               step_tick; // Conversion clock step in use.
    logic               finish;    // Last conversion step is taken now.

    // With chip select high every strobe and the clock are ignored.
    assign wr_rise  = !cs_n && !st_reg.wr_n_prev && wr_n; // see [RULE23]
    assign rd_fall  = !cs_n && st_reg.rd_n_prev && !rd_n;
    assign ext_rise = !cs_n && !st_reg.ext_prev && ext_clk;
    assign ext_fall = !cs_n && st_reg.ext_prev && !ext_clk;
    assign new_cfg  = sar_ctrl_pkg::cfg_s'(data_in);

    // The external clock is not looked at at all in internal mode.
    assign step_tick = st_reg.clk_internal ? int_tick : ext_rise; // see [RULE24]
    assign finish = (st_reg.state == sar_ctrl_pkg::SEQ_CONVERT) && step_tick &&
                    (st_reg.step == sar_ctrl_pkg::CONV_LAST_STEP); // see [RULE20]

    // Internal oscillator, running only while a conversion uses it.
    int_conv_clock #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_osc (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .run      (st_reg.clk_internal && (st_reg.state == sar_ctrl_pkg::SEQ_CONVERT)),
        .tick     (int_tick)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************

    // Next-state logic: timing of acquisition, SAR steps, then host accesses.
    // Host writes are handled last so that they override the running sequence.
    always_comb begin
        st_next = st_reg;
        st_next.wr_n_prev = wr_n;
        st_next.rd_n_prev = rd_n;
        st_next.ext_prev = ext_clk;
        unique case (st_reg.state)
            sar_ctrl_pkg::SEQ_IDLE: begin
                // Nothing runs until a control byte arrives.
                st_next.converting = 1'b0;
            end
            sar_ctrl_pkg::SEQ_ACQ_TIMED: begin
                if (st_reg.clk_internal) begin
                    // Internal clock: acquisition lasts a fixed number of core cycles.
                    st_next.acq_cnt = st_reg.acq_cnt + 1'b1;
                    if (st_reg.acq_cnt == ACQ_INT_LAST) begin // see [RULE2]
                        st_next.state = sar_ctrl_pkg::SEQ_CONVERT;
                        st_next.track = 1'b0;
                        st_next.converting = 1'b1;
                        st_next.step = 4'h0;
                    end
                end else if (ext_fall) begin
                    // External clock: hold on the fourth falling edge.
                    st_next.acq_cnt = st_reg.acq_cnt + 1'b1;
                    if (st_reg.acq_cnt == ACQ_EXT_LAST) begin // see [RULE22]
                        st_next.state = sar_ctrl_pkg::SEQ_CONVERT;
                        st_next.track = 1'b0;
                        st_next.converting = 1'b1;
                        st_next.step = 4'h0;
                    end
                end
            end
            sar_ctrl_pkg::SEQ_ACQ_HOST: begin
                // No time limit; only a further write ends this state.
                st_next.track = 1'b1; // see [RULE3]
            end
            sar_ctrl_pkg::SEQ_CONVERT: begin
                if (step_tick) begin
                    st_next.trial = sar_step(st_reg.trial, st_reg.step, comparator_high);
                    st_next.step = st_reg.step + 4'h1;
                end
                if (finish) begin
                    // Bipolar results leave as two's complement.
                    st_next.result = st_next.trial ^
                        {!st_reg.cfg.polarity_select, 11'h000}; // see [RULE14]
                    st_next.done_n = 1'b0; // see [RULE8]
                    st_next.converting = 1'b0;
                    st_next.state = sar_ctrl_pkg::SEQ_IDLE;
                end
            end
        endcase
        // A read clears completion unless a completion arrives at once.
        if (rd_fall && !finish) begin
            st_next.done_n = 1'b1; // see [RULE9]
        end
        if (wr_rise) begin
            // A new control byte clears completion; a simultaneous finish wins.
            if (!finish) begin
                st_next.done_n = 1'b1; // see [RULE9]
            end
            st_next.cfg = new_cfg; // see [RULE12] [RULE13] [RULE15]
            // Power-down codes leave the clock source as it was.
            if (new_cfg.power_clock_select_hi) begin // see [RULE10] [RULE11]
                st_next.clk_internal = !new_cfg.power_clock_select_lo; // see [RULE17]
            end
            st_next.power_down = {new_cfg.power_clock_select_hi,
                                  new_cfg.power_clock_select_lo} ==
                                 sar_ctrl_pkg::PWR_FULL_DOWN; // see [RULE11]
            st_next.standby = {new_cfg.power_clock_select_hi,
                               new_cfg.power_clock_select_lo} ==
                              sar_ctrl_pkg::PWR_STANDBY;
            st_next.acq_cnt = '0;
            st_next.step = 4'h0;
            if ((st_reg.state == sar_ctrl_pkg::SEQ_ACQ_HOST) &&
                !new_cfg.acquisition_select) begin
                // Second write of a host-timed pair: hold now and convert,
                // whatever power bits came with it.
                st_next.state = sar_ctrl_pkg::SEQ_CONVERT; // see [RULE4] [RULE6]
                st_next.track = 1'b0;
                st_next.converting = 1'b1;
            end else if (!new_cfg.power_clock_select_hi) begin
                // Power-down: the converter does not convert.
                st_next.state = sar_ctrl_pkg::SEQ_IDLE;
                st_next.track = 1'b0;
                st_next.converting = 1'b0;
            end else begin
                // Any other write, even mid-conversion, starts a fresh acquisition.
                st_next.state = new_cfg.acquisition_select ?
                    sar_ctrl_pkg::SEQ_ACQ_HOST : sar_ctrl_pkg::SEQ_ACQ_TIMED; // see [RULE1]
                st_next.track = 1'b1; // see [RULE21] [RULE22] [RULE18]
                st_next.converting = 1'b0;
            end
        end
        // The bus is driven only during a selected read.
        st_next.data_oe = !cs_n && !rd_n; // see [RULE23]
        st_next.data_out = read_byte(st_reg.result, high_byte_select,
                                     st_reg.cfg.polarity_select);
    end

    // Register the whole sequencer state; power-up selects the external clock.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_reg <= sar_ctrl_pkg::SEQ_RESET; // see [RULE16]
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // Outputs, all straight from the state register
    // ************************************************************

    assign done_n              = st_reg.done_n;
    assign data_out            = st_reg.data_out;
    assign data_oe             = st_reg.data_oe;
    assign track               = st_reg.track;
    assign converting          = st_reg.converting;
    assign sar_trial           = st_reg.trial;
    assign channel_select      = st_reg.cfg.channel_select;
    assign input_config_select = st_reg.cfg.input_config_select;
    assign polarity_select     = st_reg.cfg.polarity_select;
    assign internal_clock      = st_reg.clk_internal;
    assign power_down          = st_reg.power_down;
    assign standby             = st_reg.standby;

    // ************************************************************
    // Assertions
    // ************************************************************

    AST_TIMED_START: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE2]
        (st_reg.state == sar_ctrl_pkg::SEQ_ACQ_TIMED) && st_reg.clk_internal && !wr_rise &&
        (st_reg.acq_cnt == ACQ_INT_LAST) |=> converting && !track)
        else $error("Timed acquisition did not end on time.");

    AST_HOST_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE3]
        (st_reg.state == sar_ctrl_pkg::SEQ_ACQ_HOST) && !wr_rise
        |=> (st_reg.state == sar_ctrl_pkg::SEQ_ACQ_HOST) && track)
        else $error("Host-timed acquisition ended without a write.");

    AST_HOST_LAUNCH: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE4]
        (st_reg.state == sar_ctrl_pkg::SEQ_ACQ_HOST) && wr_rise && !data_in[5]
        |=> converting && !track && (st_reg.step == 4'h0))
        else $error("Second write did not launch conversion.");

    AST_DONE_LOW: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE8]
        finish |=> !done_n && !converting)
        else $error("Completion not flagged after last step.");

    AST_DONE_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE9]
        (wr_rise || rd_fall) && !finish |=> done_n)
        else $error("Completion not cleared by read or write.");

    AST_PD_CLOCK: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE10]
        wr_rise && !data_in[7] |=> $stable(internal_clock) &&
        (converting == $past((st_reg.state == sar_ctrl_pkg::SEQ_ACQ_HOST) && !data_in[5])))
        else $error("Power-down changed the clock source.");

    AST_CLK_DECODE: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE11]
        wr_rise && data_in[7] |=> internal_clock == !$past(data_in[6]))
        else $error("Clock source decoded wrongly.");

    AST_FIELDS: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE15]
        wr_rise |=> (channel_select == $past(data_in[2:0])) &&
                    (polarity_select == $past(data_in[3])) &&
                    (input_config_select == $past(data_in[4])))
        else $error("Control fields not taken from the write.");

    AST_ABORT: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE21]
        converting && wr_rise && data_in[7] && data_in[5] |=> track && !converting)
        else $error("Write during conversion did not restart acquisition.");

    AST_CS_OFF: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE23]
        cs_n |=> !data_oe)
        else $error("Bus driven while deselected.");

    AST_EXT_IGNORED: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE24]
        internal_clock && converting && !int_tick && !wr_rise |=> $stable(sar_trial))
        else $error("Conversion stepped without the internal clock.");

endmodule

// ---- sim/host_model.sv ----
// Host model: drives chip select, write and read strobes of the converter.
// Assumes the bench calls its tasks from falling clock edges.
`timescale 1ns/1ps
module host_model (
    input  wire logic  core_clk,
    output logic       cs_n,
    output logic       wr_n,
    output logic       rd_n,
    output logic [7:0] data_in
);
    // Chip select starts low; sel lets the bench deselect the converter.
    initial {cs_n, wr_n, rd_n, data_in} = 11'h300;
    // Write pulse; the bus shows the inverse once the byte is taken.
    task automatic wr(input logic [7:0] b);
        @(negedge core_clk) {wr_n, data_in} = {1'b0, b};
        @(negedge core_clk) wr_n = 1'b1;
        @(negedge core_clk) data_in = ~b;
        @(negedge core_clk);
    endtask
    // Read pulse, two cycles long.
    task automatic rd();
        @(negedge core_clk) rd_n = 1'b0;
        repeat (2) @(negedge core_clk);
        rd_n = 1'b1;
        @(negedge core_clk);
    endtask
    // Chip select change on the next falling edge.
    task automatic sel(input logic v);
        @(negedge core_clk) cs_n = v;
    endtask
endmodule

// ---- sim/sar_adc_control_sequencer_tb_top.sv ----
// Bench top: drives the sequencer through the host model and checks outputs.
// Assumes small acquisition and step counts so the run stays short.
`timescale 1ns/1ps
module sar_adc_control_sequencer_tb_top;
    logic core_clk = 1'b0, rst_n = 1'b0, ext_clk = 1'b0, oe_prev = 1'b0;
    logic high_byte_select = 1'b0, comparator_high = 1'b0;
    logic cs_n, wr_n, rd_n, done_n, data_oe, track, converting, internal_clock;
    logic input_config_select, polarity_select, power_down, standby;
    logic [7:0] data_in, data_out;
    logic [2:0] channel_select, ch;
    logic [7:0] exp_q[$];
    logic [11:0] sar_trial;
    logic [11:0] mexp[4] = '{12'h6, 12'h5, 12'h4, 12'h0};
    int err_total = 0, cmp_count = 0, cyc = 0, seed = 32'h898f28cd;
    sar_adc_control_sequencer #(.ACQ_CYCLES(4), .STEP_CYCLES(3)) u_dut (.*);
    host_model u_host (.*);
    // Edges land on falling core edges, so sampling never races.
    always #4 core_clk = ~core_clk;
    always #24 ext_clk = ~ext_clk;
    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("Compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wait_done();
        int n = 0;
        while (done_n !== 1'b0 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        chk("done_n low", {11'h0, done_n}, 12'h0);
    endtask
    task automatic rd_chk(input logic sel, input logic [7:0] e);
        high_byte_select = sel;
        exp_q.push_back(e);
        u_host.rd();
        chk("done_n high", {11'h0, done_n}, 12'h1);
    endtask
    // Each read result is compared with the oldest expectation.
    always @(negedge core_clk) begin
        oe_prev <= data_oe;
        if (data_oe === 1'b1 && oe_prev === 1'b0)
            chk("data_out", {4'h0, data_out}, {4'h0, exp_q.pop_front()});
    end
    // A hang is cut short and counted as a mismatch.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        chk("clock at reset", {11'h0, internal_clock}, 12'h0);
        ch = 3'($random(seed));
        comparator_high = 1'b1;
        u_host.wr({5'h13, ch});
        chk("clock", {11'h0, internal_clock}, 12'h1);
        chk("cfg", {10'h0, input_config_select, polarity_select}, 12'h3);
        chk("channel", {9'h0, channel_select}, {9'h0, ch});
        repeat (2) @(negedge core_clk);
        chk("acq", {10'h0, track, converting}, 12'h2);
        @(negedge core_clk);
        chk("conv start", {11'h0, converting}, 12'h1);
        wait_done();
        chk("trial", sar_trial, 12'hfff);
        rd_chk(1'b1, 8'h0f);
        rd_chk(1'b0, 8'hff);
        $display("Test timed acquisition done");
        for (int m = 0; m < 4; m++) begin
            u_host.wr({2'(m), 6'h00});
            chk("mode", {9'h0, internal_clock, power_down, standby}, mexp[m]);
        end
        // Deselected: the write and the read must both go unheard.
        u_host.sel(1'b1);
        u_host.wr(8'h80);
        u_host.rd();
        u_host.sel(1'b0);
        chk("deselected", {9'h0, internal_clock, power_down, standby}, 12'h0);
        $display("Test power modes done");
        comparator_high = 1'b0;
        u_host.wr({5'h1c, ch});
        repeat (50) @(negedge core_clk);
        chk("host acq", {10'h0, track, converting}, 12'h2);
        u_host.wr({5'h10, ch});
        chk("launch", {10'h0, converting, internal_clock}, 12'h3);
        u_host.wr({5'h1c, ch});
        chk("abort", {10'h0, track, converting}, 12'h2);
        u_host.wr({5'h18, ch});
        wait_done();
        chk("trial", sar_trial, 12'h000);
        rd_chk(1'b1, 8'hf8);
        rd_chk(1'b0, 8'h00);
        chk("unread", 12'(exp_q.size()), 12'h000);
        $display("Test host acquisition done");
        report_and_stop();
    end
endmodule
